/* File: src/filt_lines_if.sv */
// Filtered bus line levels from the link-clock front end
`timescale 1ns/1ps
`default_nettype none

interface filt_lines_if;
	logic scl;
	logic sda;
	modport front (output scl, output sda);
	modport core  (input  scl, input  sda);
endinterface

`default_nettype wire

/* File: src/line_filter.sv */
// Link-clock front end: pin synchronisers and spike filters for both bus lines
`timescale 1ns/1ps
`default_nettype none
`include "sink_ctrl_regs.svh"

module line_filter
	import sink_ctrl_pkg::*;
(
	// Link sample clock and controls from the main domain
	input  wire logic    link_clk,
	input  wire logic    reset,
	input  wire logic    ce,
	// Bus pins
	input  wire logic    scl_in,
	input  wire logic    sda_in,
	// Filtered levels
	filt_lines_if.front  lines
);

	link_state_t st_ff;
	link_state_t nxt_st;
	logic [1:0]  pins;

	assign pins = {sda_in, scl_in};

	always_comb begin
		nxt_st = st_ff;
		nxt_st.rst_s = {st_ff.rst_s[0], reset};
		nxt_st.ce_s = {st_ff.ce_s[0], ce};
		for (int i = 0; i < 2; i++) begin
			nxt_st.pin_s[i] = {st_ff.pin_s[i][0], pins[i]};
			// A new level must persist past the spike width before it counts
			if (st_ff.pin_s[i][1] != st_ff.filt[i]) begin
				if (st_ff.cnt[i] == 4'(`SPIKE_CYCLES - 1)) begin
					nxt_st.filt[i] = st_ff.pin_s[i][1];
					nxt_st.cnt[i] = 4'h0;
				end else begin
					nxt_st.cnt[i] = st_ff.cnt[i] + 4'h1;
				end
			end else begin
				nxt_st.cnt[i] = 4'h0;
			end
		end
		if (st_ff.rst_s[1]) begin
			nxt_st.pin_s = 4'hF;
			nxt_st.cnt = 8'h00;
			nxt_st.filt = 2'h3;
		end else if (!st_ff.ce_s[1]) begin
			nxt_st.pin_s = st_ff.pin_s;
			nxt_st.cnt = st_ff.cnt;
			nxt_st.filt = st_ff.filt;
		end
	end

	always_ff @(posedge link_clk) begin
		st_ff <= nxt_st;
	end

	assign lines.scl = st_ff.filt[0];
	assign lines.sda = st_ff.filt[1];

endmodule

`default_nettype wire

/* File: src/sink_ctrl_i2c.sv */
// Two-wire slave with the status/control and four channel level registers
`timescale 1ns/1ps
`default_nettype none
`include "sink_ctrl_regs.svh"

module sink_ctrl_i2c
	import sink_ctrl_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
	// Clocks, reset, enable
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic             ce,
	input  wire logic             link_clk,
	// Bus pins
	input  wire logic             scl_in,
	input  wire logic             sda_in,
	output logic                  sda_out,
	output logic                  sda_oe,
	// Analog monitors
	input  wire logic             overtemp_flag,
	input  wire logic             undervoltage_lockout,
	// Controls to the sinks
	output logic [1:0]            power_mode,
	output logic [3:0]            chan_enable,
	output logic [3:0]            chan_drive,
	output logic [3:0][5:0]       current_code,
	output logic                  bus_ready
);

	core_state_t st_ff;
	core_state_t nxt_st;

	filt_lines_if lines ();

	line_filter u_filter (
		.link_clk (link_clk),
		.reset    (reset),
		.ce       (ce),
		.scl_in   (scl_in),
		.sda_in   (sda_in),
		.lines    (lines.front)
	);

	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic timeout_hit;
	logic both_low;

	assign scl = st_ff.scl_s[1];
	assign sda = st_ff.sda_s[1];
	assign scl_rise = scl & ~st_ff.scl_d;
	assign scl_fall = ~scl & st_ff.scl_d;
	assign start_cond = scl & st_ff.scl_d & st_ff.sda_d & ~sda;
	assign stop_cond = scl & st_ff.scl_d & ~st_ff.sda_d & sda;
	assign both_low = ~scl & ~sda;
	assign timeout_hit = both_low && (st_ff.tmo == 22'(TIMEOUT_CYCLES - 1));

	// Byte order on reads: status first, then channels in order
	function automatic logic [7:0] rd_byte(input core_state_t s, input logic [2:0] idx);
		logic [7:0] b;
		b = 8'h00;
		if (idx == 3'h0) begin
			b = {s.mode, s.en, s.ovt_s[1], s.uv_s[1]};
		end else begin
			b = s.chan[2'(idx - 3'h1)];
		end
		return b;
	endfunction

	always_comb begin
		logic [2:0] nidx;
		logic [7:0] nb;
		nidx = 3'h0;
		nb = 8'h00;
		nxt_st = st_ff;
		nxt_st.scl_s = {st_ff.scl_s[0], lines.scl};
		nxt_st.sda_s = {st_ff.sda_s[0], lines.sda};
		nxt_st.scl_d = scl;
		nxt_st.sda_d = sda;
		nxt_st.ovt_s = {st_ff.ovt_s[0], overtemp_flag};
		nxt_st.uv_s = {st_ff.uv_s[0], undervoltage_lockout};

		// ****************************************************************
		// Startup after lockout
		// ****************************************************************
		if (st_ff.uv_s[1]) begin
			nxt_st.startup = 5'h00;
			nxt_st.ready = 1'b0;
		end else if (!st_ff.ready) begin
			nxt_st.startup = st_ff.startup + 5'h01;
			if (st_ff.startup == 5'(`STARTUP_CYCLES - 1)) begin
				nxt_st.ready = 1'b1;
			end
		end

		// ****************************************************************
		// Stuck-low timeout
		// ****************************************************************
		if (!both_low) begin
			nxt_st.tmo = 22'h0;
		end else if (!timeout_hit) begin
			nxt_st.tmo = st_ff.tmo + 22'h1;
		end

		// ****************************************************************
		// Bus protocol
		// ****************************************************************
		if (timeout_hit || !nxt_st.ready) begin
			// Lockout holds the bus idle so a half-seen frame is dropped
			nxt_st.fsm = ST_IDLE;
			nxt_st.sda_oe = 1'b0;
			if (timeout_hit) begin
				nxt_st.mode = `MODE_SHUT_CLEAR;
				nxt_st.en = 4'h0;
				nxt_st.chan = 32'h0;
			end
		end else if (start_cond) begin
			nxt_st.fsm = ST_ADDR;
			nxt_st.bitcnt = 4'h0;
			nxt_st.idx = 3'h0;
			nxt_st.sda_oe = 1'b0;
		end else if (stop_cond) begin
			nxt_st.fsm = ST_IDLE;
			nxt_st.sda_oe = 1'b0;
		end else begin
			case (st_ff.fsm)
				ST_ADDR, ST_WR: begin
					if (scl_rise) begin
						nxt_st.shift = {st_ff.shift[6:0], sda};
						nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
					end else if (scl_fall && st_ff.bitcnt == 4'h8) begin
						if (st_ff.fsm == ST_ADDR) begin
							if (st_ff.shift[7:1] == `SLAVE_ADDR) begin
								nxt_st.fsm = ST_ADDR_ACK;
								nxt_st.sda_oe = 1'b1;
								nxt_st.rw = st_ff.shift[0];
							end else begin
								nxt_st.fsm = ST_IDLE;
							end
						end else begin
							nxt_st.fsm = ST_WR_ACK;
							if (st_ff.idx < `NUM_REGS) begin
								nxt_st.sda_oe = 1'b1;
								nxt_st.idx = st_ff.idx + 3'h1;
								if (st_ff.idx == 3'h0) begin
									if (st_ff.shift[`MODE_MSB:`MODE_LSB] == `MODE_SHUT_CLEAR) begin
										nxt_st.mode = `MODE_SHUT_CLEAR;
										nxt_st.en = 4'h0;
										nxt_st.chan = 32'h0;
									end else begin
										nxt_st.mode = st_ff.shift[`MODE_MSB:`MODE_LSB];
										nxt_st.en = st_ff.shift[`EN_MSB:`EN_LSB];
									end
								end else if (st_ff.mode != `MODE_SHUT_CLEAR) begin
									// Mode 00 pins every channel register at zero
									nxt_st.chan[2'(st_ff.idx - 3'h1)] = st_ff.shift;
								end
							end
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						nxt_st.bitcnt = 4'h0;
						if (st_ff.rw) begin
							nb = rd_byte(st_ff, st_ff.idx);
							nxt_st.fsm = ST_RD;
							nxt_st.shift = nb;
							nxt_st.sda_oe = ~nb[7];
						end else begin
							nxt_st.fsm = ST_WR;
							nxt_st.sda_oe = 1'b0;
						end
					end
				end
				ST_WR_ACK: begin
					if (scl_fall) begin
						nxt_st.fsm = ST_WR;
						nxt_st.bitcnt = 4'h0;
						nxt_st.sda_oe = 1'b0;
					end
				end
				ST_RD: begin
					if (scl_fall) begin
						if (st_ff.bitcnt == 4'h7) begin
							nxt_st.fsm = ST_RD_ACK;
							nxt_st.sda_oe = 1'b0;
						end else begin
							nxt_st.shift = {st_ff.shift[6:0], 1'b0};
							nxt_st.sda_oe = ~st_ff.shift[6];
							nxt_st.bitcnt = st_ff.bitcnt + 4'h1;
						end
					end
				end
				ST_RD_ACK: begin
					if (scl_rise) begin
						nxt_st.mnack = sda;
					end else if (scl_fall) begin
						if (st_ff.mnack) begin
							nxt_st.fsm = ST_IDLE;
						end else begin
							nidx = (st_ff.idx == `LAST_CHAN_IDX) ? 3'h0 : st_ff.idx + 3'h1;
							nb = rd_byte(st_ff, nidx);
							nxt_st.idx = nidx;
							nxt_st.fsm = ST_RD;
							nxt_st.bitcnt = 4'h0;
							nxt_st.shift = nb;
							nxt_st.sda_oe = ~nb[7];
						end
					end
				end
				default: begin
					nxt_st.fsm = ST_IDLE;
				end
			endcase
		end

		for (int i = 0; i < 4; i++) begin
			nxt_st.drive[i] = (nxt_st.mode == `MODE_ACTIVE) & nxt_st.en[i];
		end

		if (reset) begin
			nxt_st = '0;
			nxt_st.fsm = ST_IDLE;
			nxt_st.scl_s = 2'h3;
			nxt_st.sda_s = 2'h3;
			nxt_st.scl_d = 1'b1;
			nxt_st.sda_d = 1'b1;
		end else if (!ce) begin
			nxt_st = st_ff;
		end
	end

	always_ff @(posedge clk) begin
		st_ff <= nxt_st;
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	// Open-drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = st_ff.sda_oe;
	assign power_mode = st_ff.mode;
	assign chan_enable = st_ff.en;
	assign chan_drive = st_ff.drive;
	assign bus_ready = st_ff.ready;

	for (genvar g = 0; g < 4; g++) begin : g_code
		assign current_code[g] = st_ff.chan[g][`CODE_MSB:`CODE_LSB];
	end

endmodule

`default_nettype wire

/* File: src/sink_ctrl_pkg.sv */
// Types shared by the sink controller modules
package sink_ctrl_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_WR,
		ST_WR_ACK,
		ST_RD,
		ST_RD_ACK
	} i2c_state_t;

	typedef struct packed {
		logic [1:0]       scl_s;
		logic [1:0]       sda_s;
		logic             scl_d;
		logic             sda_d;
		logic [1:0]       ovt_s;
		logic [1:0]       uv_s;
		i2c_state_t       fsm;
		logic [3:0]       bitcnt;
		logic [7:0]       shift;
		logic [2:0]       idx;
		logic             rw;
		logic             mnack;
		logic             sda_oe;
		logic [4:0]       startup;
		logic             ready;
		logic [21:0]      tmo;
		logic [1:0]       mode;
		logic [3:0]       en;
		logic [3:0][7:0]  chan;
		logic [3:0]       drive;
	} core_state_t;

	typedef struct packed {
		logic [1:0]       rst_s;
		logic [1:0]       ce_s;
		logic [1:0][1:0]  pin_s;
		logic [1:0][3:0]  cnt;
		logic [1:0]       filt;
	} link_state_t;

endpackage

/* File: src/sink_ctrl_regs.svh */
// Register layout, bus address and timing counts of the sink controller
`ifndef SINK_CTRL_REGS_SVH
`define SINK_CTRL_REGS_SVH

// ****************************************************************
// Bus address and register map
// ****************************************************************
`define SLAVE_ADDR        7'h38
`define NUM_REGS          3'h5
`define LAST_CHAN_IDX     3'h4
`define REG_RESET         8'h00

// ****************************************************************
// Status/control and channel code field positions
// ****************************************************************
`define MODE_MSB          7
`define MODE_LSB          6
`define EN_MSB            5
`define EN_LSB            2
`define OVERTEMP_BIT      1
`define UNDERVOLT_BIT     0
`define CODE_MSB          7
`define CODE_LSB          2

// ****************************************************************
// Power-mode encodings
// ****************************************************************
`define MODE_SHUT_CLEAR   2'h0
`define MODE_SHUT_KEEP    2'h1
`define MODE_STANDBY      2'h2
`define MODE_ACTIVE       2'h3

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS     40
`define LINK_PERIOD_PS    6000
`define SPIKE_NS          50
// One extra sample: a pulse touches one more sample than it spans periods
`define SPIKE_CYCLES      (((`SPIKE_NS * 1000 + `LINK_PERIOD_PS - 1) / `LINK_PERIOD_PS) + 1)
`define STARTUP_US        1
`define STARTUP_CYCLES    ((`STARTUP_US * 1000) / `CLK_PERIOD_NS)
`define TIMEOUT_MS        90
`define TIMEOUT_CYCLES    ((`TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)

`endif

/* File: testbench/i2c_master_model.sv */
// Two-wire bus master model; data line is open drain with pull-up
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
	// Clock and bus
	input  wire logic clk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic hp(input int n = 32);
		repeat (n) @(negedge clk);
	endtask
	task automatic start;
		hp;
		sda = 1'b0;
		hp;
		scl = 1'b0;
		hp(10);
	endtask
	task automatic stop;
		sda = 1'b0;
		hp;
		scl = 1'b1;
		hp;
		sda = 1'b1;
		hp;
	endtask
	// Data changes only well after the clock fall, never next to it
	task automatic bit_io(input logic b, output logic r);
		sda = b;
		hp;
		scl = 1'b1;
		hp;
		r = sda_line;
		scl = 1'b0;
		hp(10);
	endtask
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
		output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(last, r);
		ack = ~r;
	endtask
	// Longer than a main clock period, so only the spike filter can hide it
	task automatic glitch;
		#10 scl = 1'b1;
		#45 scl = 1'b0;
		hp(1);
	endtask
	task automatic both_low(input int n);
		sda = 1'b0;
		hp;
		scl = 1'b0;
		hp(n);
		scl = 1'b1;
		hp;
		sda = 1'b1;
		hp;
	endtask
endmodule
`default_nettype wire

/* File: testbench/sink_ctrl_checker.sv */
// Port assertions for the sink controller register slave
`timescale 1ns/1ps
`default_nettype none
module sink_ctrl_checker #(
	parameter int unsigned TIMEOUT_CYCLES = 200
) (
	// Clocks and controls
	input wire logic            clk,
	input wire logic            reset,
	input wire logic            ce,
	input wire logic            link_clk,
	// Bus pins
	input wire logic            scl_in,
	input wire logic            sda_in,
	input wire logic            sda_out,
	input wire logic            sda_oe,
	// Monitors and sink controls
	input wire logic            overtemp_flag,
	input wire logic            undervoltage_lockout,
	input wire logic [1:0]      power_mode,
	input wire logic [3:0]      chan_enable,
	input wire logic [3:0]      chan_drive,
	input wire logic [3:0][5:0] current_code,
	input wire logic            bus_ready
);
	logic [31:0] low_ff;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// Raw both-low time; the margin covers filter and sync delay
	always_ff @(posedge clk) begin
		if (reset || scl_in || sda_in) begin
			low_ff <= 32'h0;
		end else if (low_ff != 32'hFFFFFFFF) begin
			low_ff <= low_ff + 32'h1;
		end
	end
	sequence s_quiet;
		!bus_ready [*8];
	endsequence
	sequence s_wake;
		bus_ready [*2];
	endsequence
	a_reset_startup: assert property ($fell(reset) && !undervoltage_lockout |->
		s_quiet ##[12:24] s_wake) else $error("bus not ready in time after reset");
	a_startup_bound: assert property ($fell(undervoltage_lockout) |-> ##[1:28] bus_ready)
		else $error("bus not ready in time after lockout");
	a_lockout_idle: assert property (undervoltage_lockout [*4] |-> !bus_ready)
		else $error("bus ready during lockout");
	a_idle_quiet: assert property (!bus_ready |-> !sda_oe)
		else $error("data driven while not ready");
	a_oe_low_phase: assert property ($changed(sda_oe) && bus_ready |-> !scl_in)
		else $error("data output changed while clock high");
	a_drive_active: assert property (chan_drive ==
		({4{power_mode == 2'h3}} & chan_enable)) else $error("drive mismatch");
	a_clear_mode: assert property (power_mode == 2'h0 |->
		chan_enable == 4'h0 && current_code == 24'h0) else $error("clear mode kept data");
	a_timeout_clear: assert property (low_ff == TIMEOUT_CYCLES + 32'h14 |->
		power_mode == 2'h0 && current_code == 24'h0) else $error("timeout did not clear");
endmodule
bind sink_ctrl_i2c sink_ctrl_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) sink_ctrl_checker_i (
	.clk, .reset, .ce, .link_clk, .scl_in, .sda_in, .sda_out, .sda_oe, .overtemp_flag,
	.undervoltage_lockout, .power_mode, .chan_enable, .chan_drive, .current_code, .bus_ready);
`default_nettype wire

/* File: testbench/tb_top.sv */
// Self-checking bench for the sink controller register slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic            clk, link_clk, reset, ce, m_scl, m_sda, sda_out, sda_oe, bus_ready;
	logic            overtemp_flag, undervoltage_lockout;
	logic [1:0]      power_mode;
	logic [3:0]      chan_enable, chan_drive;
	logic [3:0][5:0] current_code;
	logic [47:0]     rd;
	logic [6:0]      ak;
	int              fails, checks;
	wire             sda_line = m_sda & ~sda_oe;
	sink_ctrl_i2c #(.TIMEOUT_CYCLES(200)) sink_ctrl_i2c_i (.clk, .reset, .ce, .link_clk,
		.scl_in(m_scl), .sda_in(sda_line), .sda_out, .sda_oe, .overtemp_flag,
		.undervoltage_lockout, .power_mode, .chan_enable, .chan_drive, .current_code, .bus_ready);
	i2c_master_model i2c_master_model_i (.clk, .sda_line, .scl(m_scl), .sda(m_sda));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	task automatic results;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	function automatic logic [47:0] st;
		return {5'h0, sda_out, bus_ready, ak, power_mode, chan_enable, chan_drive, current_code};
	endfunction
	task automatic wait_ready(input int lim);
		for (int i = 0; i < lim && bus_ready !== 1'b1; i++) begin
			@(negedge clk);
		end
		if (bus_ready !== 1'b1) begin
			fails++;
			results;
		end
	endtask
	// Address byte, then n bytes: written from wd or read into rd
	task automatic xact(input logic [7:0] adr, input int n, input logic [47:0] wd,
		input logic g);
		logic [7:0] q;
		logic       a;
		rd = 48'h0;
		ak = 7'h0;
		i2c_master_model_i.start;
		if (g) begin
			i2c_master_model_i.glitch;
		end
		i2c_master_model_i.xfer(adr, 1'b1, q, a);
		ak[6] = a;
		for (int i = 0; i < n; i++) begin
			i2c_master_model_i.xfer(adr[0] ? 8'hFF : wd[47-8*i -: 8], !adr[0] || i == n - 1, q, a);
			rd[47-8*i -: 8] = q;
			ak[5-i] = a;
		end
		i2c_master_model_i.stop;
	endtask
	task automatic s_full_write;
		xact(8'h70, 6, 48'hFC0780FE5400, 1'b0);
		chk(st(), {6'h0, 1'b1, 7'h7E, 2'h3, 4'hF, 4'hF, 24'h57F801});
	endtask
	task automatic s_read;
		overtemp_flag = 1'b1;
		xact(8'h71, 6, 48'h0, 1'b0);
		chk(rd & 48'hFFFCFCFCFCFF, 48'hFE0480FC54FE);
		overtemp_flag = 1'b0;
	endtask
	task automatic s_modes;
		for (int m = 3; m >= 0; m--) begin
			xact(8'h70, 1, {m[1:0], 46'h3C0000000000}, 1'b0);
			chk(st(), {7'h1, 7'h60, m[1:0], m == 0 ? 4'h0 : 4'hF, m == 3 ? 4'hF : 4'h0,
				m == 0 ? 24'h0 : 24'h57F801});
		end
	endtask
	task automatic s_glitch_addr;
		xact(8'h70, 1, 48'hC40000000000, 1'b1);
		chk(st(), {7'h1, 7'h60, 2'h3, 4'h1, 4'h1, 24'h0});
		xact(8'h72, 1, 48'h0, 1'b0);
		chk(st(), {7'h1, 7'h00, 2'h3, 4'h1, 4'h1, 24'h0});
	endtask
	task automatic s_timeout;
		i2c_master_model_i.both_low(300);
		chk(st(), {7'h1, 7'h00, 2'h0, 4'h0, 4'h0, 24'h0});
		xact(8'h70, 1, 48'hC40000000000, 1'b0);
		chk(st(), {7'h1, 7'h60, 2'h3, 4'h1, 4'h1, 24'h0});
	endtask
	task automatic s_startup;
		undervoltage_lockout = 1'b1;
		repeat (8) @(negedge clk);
		xact(8'h70, 1, 48'h0, 1'b0);
		chk(st(), {7'h0, 7'h00, 2'h3, 4'h1, 4'h1, 24'h0});
		undervoltage_lockout = 1'b0;
		wait_ready(28);
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		results;
	end
	initial begin
		fails = 0;
		checks = 0;
		reset = 1'b1;
		ce = 1'b1;
		overtemp_flag = 1'b0;
		undervoltage_lockout = 1'b0;
		repeat (4) @(negedge clk);
		reset = 1'b0;
		wait_ready(40);
		s_full_write;
		s_read;
		s_modes;
		s_glitch_addr;
		s_timeout;
		s_startup;
		results;
	end
endmodule
`default_nettype wire
